// *** aocs_top.sv ***
// Module: always-on clock select, divide and gate slice with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module aocs_top (
  input wire logic aclk, // System clock, 10 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [aocs_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [aocs_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic crystal_clock, // Crystal source pulse
  input wire logic gpll_clock, // General PLL source pulse
  input wire logic usbphy480_clock, // USB PHY 480M source pulse
  input wire logic npll_clock, // Second PLL source pulse
  input wire logic monitor_src_clock, // Monitor clock source pulse
  input wire logic bus_src_clock, // Always-on bus clock source pulse
  output logic wifi_clock_out, // Wireless module clock
  output logic dsi_phy_ref_clock, // Display PHY reference
  output logic usb_phy_ref_clock, // USB PHY reference
  output logic serial0_clock, // Serial port final clock
  output logic div32k_src_clock, // Source of 32.768k fractional divider
  output logic oscdiv_src_clock, // Source of oscillator function divider
  output logic monitor_clock, // Gated monitor clock
  output logic [aocs_pkg::BUS_N-1:0] bus_clock // Gated bus clocks
);

  typedef struct packed {
    logic [15:0] r_wifi;
    logic [15:0] r_ssrc;
    logic [15:0] r_sout;
    logic [31:0] r_frac;
    logic [15:0] r_ga;
    logic [15:0] r_gb;
    logic aw_have;
    logic [aocs_pkg::ADDR_W-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [6:0] half_acc;
    logic [aocs_pkg::FRAC_W-1:0] frac_acc;
    logic half_tick;
    logic frac_tick;
    logic wifi_eff;
    logic dsi_eff;
    logic usb_eff;
    logic [1:0] spll_eff;
    logic [1:0] sfin_eff;
    logic wifi_out;
    logic dsi_out;
    logic usb_out;
    logic ser_out;
    logic d32k_out;
    logic oscd_out;
    logic mon_out;
    logic [aocs_pkg::BUS_N-1:0] bus_out;
  } aocs_main_st_t;

  localparam aocs_main_st_t MAIN_RST = '{
    r_wifi: aocs_pkg::WIFI_SEL_RST, r_ssrc: aocs_pkg::SER_SRC_RST,
    r_sout: aocs_pkg::SER_OUT_RST, r_frac: aocs_pkg::SER_FRAC_RST,
    r_ga: aocs_pkg::GATE_RST, r_gb: aocs_pkg::GATE_RST,
    aw_have: 1'b0, awaddr: 16'h0000, w_have: 1'b0, wdata: 32'h0, wstrb: 4'h0,
    bvalid: 1'b0, bresp: aocs_pkg::RESP_OKAY, rvalid: 1'b0, rdata: 32'h0,
    rresp: aocs_pkg::RESP_OKAY, half_acc: 7'h00, frac_acc: 16'h0000,
    half_tick: 1'b0, frac_tick: 1'b0, wifi_eff: 1'b0, dsi_eff: 1'b0, usb_eff: 1'b0,
    spll_eff: aocs_pkg::SRC_GPLL, sfin_eff: aocs_pkg::FIN_INT,
    wifi_out: 1'b0, dsi_out: 1'b0, usb_out: 1'b0, ser_out: 1'b0, d32k_out: 1'b0,
    oscd_out: 1'b0, mon_out: 1'b0, bus_out: 9'h000};

  aocs_main_st_t st_q;
  aocs_main_st_t st_d;
  logic wr_now;
  logic spll_pulse;
  logic [2:0] div_tick;
  logic [2:0] div_src;
  logic [2:0] div_run;
  logic [aocs_pkg::DIV_W-1:0] div_val [3];

  // Masked write: a bit moves only when its mask bit and both byte lanes allow it
  function automatic logic [15:0] mwrite(input logic [15:0] old, input logic [15:0] d,
                                         input logic [15:0] k);
    mwrite = (old & ~k) | (d & k);
  endfunction : mwrite

  // ----------------------------------------------------------------
  // Dividers: wireless, 24M reference, serial integer
  // ----------------------------------------------------------------
  // Serial source mux works on the handed-over select only
  always_comb begin
    case (st_q.spll_eff)
      aocs_pkg::SRC_GPLL: spll_pulse = gpll_clock;
      aocs_pkg::SRC_XTAL: spll_pulse = crystal_clock;
      aocs_pkg::SRC_USB480: spll_pulse = usbphy480_clock;
      aocs_pkg::SRC_NPLL: spll_pulse = npll_clock;
      default: spll_pulse = 1'b0;
    endcase
  end

  // Divider inputs and source gates
  assign div_src = {spll_pulse, gpll_clock, gpll_clock};
  assign div_run[0] = !st_q.r_ga[aocs_pkg::GA_WIFI_PLL];
  assign div_run[1] = !st_q.r_gb[aocs_pkg::GB_R24PLL];
  assign div_run[2] = !st_q.r_gb[aocs_pkg::GB_SPLL];
  assign div_val[0] = st_q.r_wifi[aocs_pkg::WDIV_LSB +: aocs_pkg::DIV_W];
  assign div_val[1] = st_q.r_wifi[aocs_pkg::R24_LSB +: aocs_pkg::DIV_W];
  assign div_val[2] = {1'b0, st_q.r_ssrc[aocs_pkg::SDIV_LSB +: aocs_pkg::SDIV_W]};

  // One divider per entry
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_div
      aocs_div_if dif();
      assign dif.tick_in = div_src[gi];
      assign dif.run = div_run[gi];
      assign dif.divisor = div_val[gi];
      assign div_tick[gi] = dif.tick_out;
      aocs_int_div u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .dv(dif.div)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state: bus slave, dividers, muxes and gates
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] be;
    logic [15:0] k;
    logic [6:0] lim;
    logic [16:0] fsum;
    logic [aocs_pkg::FRAC_W-1:0] num;
    logic [aocs_pkg::FRAC_W-1:0] den;
    logic fin;
    be = 32'h0;
    k = 16'h0000;
    lim = 7'h00;
    fsum = 17'h00000;
    num = st_q.r_frac[aocs_pkg::NUM_LSB +: aocs_pkg::FRAC_W];
    den = st_q.r_frac[aocs_pkg::DEN_LSB +: aocs_pkg::FRAC_W];
    fin = 1'b0;
    st_d = st_q;
    wr_now = 1'b0;

    // Address and data are taken independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_have = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
      wr_now = 1'b1;
      be = {{8{st_q.wstrb[3]}}, {8{st_q.wstrb[2]}}, {8{st_q.wstrb[1]}}, {8{st_q.wstrb[0]}}};
      k = st_q.wdata[31:16] & be[31:16] & be[15:0];
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = aocs_pkg::RESP_OKAY;
      case (st_q.awaddr)
        aocs_pkg::OFF_WIFI_SEL: begin
          st_d.r_wifi = mwrite(st_q.r_wifi, st_q.wdata[15:0], k & aocs_pkg::WIFI_SEL_RW);
        end
        aocs_pkg::OFF_SER_SRC: begin
          st_d.r_ssrc = mwrite(st_q.r_ssrc, st_q.wdata[15:0], k & aocs_pkg::SER_SRC_RW);
        end
        aocs_pkg::OFF_SER_OUT: begin
          st_d.r_sout = mwrite(st_q.r_sout, st_q.wdata[15:0], k & aocs_pkg::SER_OUT_RW);
        end
        aocs_pkg::OFF_SER_FRAC: begin
          st_d.r_frac = (st_q.r_frac & ~be) | (st_q.wdata & be); // Unmasked word
        end
        aocs_pkg::OFF_GATE_A: begin
          st_d.r_ga = mwrite(st_q.r_ga, st_q.wdata[15:0], k & aocs_pkg::GATE_A_RW);
        end
        aocs_pkg::OFF_GATE_B: begin
          st_d.r_gb = mwrite(st_q.r_gb, st_q.wdata[15:0], k & aocs_pkg::GATE_B_RW);
        end
        default: begin
          st_d.bresp = aocs_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Reads answer one cycle after the address; the mask half reads zero
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = aocs_pkg::RESP_OKAY;
      case (s_axi_araddr)
        aocs_pkg::OFF_WIFI_SEL: st_d.rdata = {16'h0000, st_q.r_wifi};
        aocs_pkg::OFF_SER_SRC: st_d.rdata = {16'h0000, st_q.r_ssrc};
        aocs_pkg::OFF_SER_OUT: st_d.rdata = {16'h0000, st_q.r_sout};
        aocs_pkg::OFF_SER_FRAC: st_d.rdata = st_q.r_frac;
        aocs_pkg::OFF_GATE_A: st_d.rdata = {16'h0000, st_q.r_ga};
        aocs_pkg::OFF_GATE_B: st_d.rdata = {16'h0000, st_q.r_gb};
        default: begin
          st_d.rdata = 32'h0;
          st_d.rresp = aocs_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Hand a select over only in a cycle with no candidate pulse, so none is cut
    if (!crystal_clock && !div_tick[0]) begin
      st_d.wifi_eff = st_q.r_wifi[aocs_pkg::WIFI_SEL_BIT];
    end
    if (!crystal_clock && !div_tick[1]) begin
      st_d.dsi_eff = st_q.r_wifi[aocs_pkg::DSI_SEL_BIT];
      st_d.usb_eff = st_q.r_wifi[aocs_pkg::USB_SEL_BIT];
    end
    if (!(gpll_clock || crystal_clock || usbphy480_clock || npll_clock)) begin
      st_d.spll_eff = st_q.r_ssrc[aocs_pkg::SPLL_LSB +: aocs_pkg::SEL_W];
    end
    if (!(div_tick[2] || st_q.half_tick || st_q.frac_tick)) begin
      st_d.sfin_eff = st_q.r_sout[aocs_pkg::SFIN_LSB +: aocs_pkg::SEL_W];
    end

    // Half-step: add two per input pulse, emit and subtract at 2n+3
    st_d.half_tick = 1'b0;
    lim = {1'b0, st_q.r_sout[aocs_pkg::HDIV_LSB +: aocs_pkg::SDIV_W], 1'b0} + aocs_pkg::HALF_OFS;
    if (div_tick[2] && !st_q.r_gb[aocs_pkg::GB_HALF]) begin
      if (st_q.half_acc + aocs_pkg::HALF_STEP >= lim) begin
        st_d.half_acc = st_q.half_acc + aocs_pkg::HALF_STEP - lim;
        st_d.half_tick = 1'b1;
      end else begin
        st_d.half_acc = st_q.half_acc + aocs_pkg::HALF_STEP;
      end
    end

    // Fractional: phase accumulator; a zero denominator holds the output still
    st_d.frac_tick = 1'b0;
    if (div_tick[2] && !st_q.r_gb[aocs_pkg::GB_FRAC] && den != 16'h0000) begin
      fsum = {1'b0, st_q.frac_acc} + {1'b0, num};
      if (fsum >= {1'b0, den}) begin
        st_d.frac_acc = 16'(fsum - {1'b0, den});
        st_d.frac_tick = 1'b1;
      end else begin
        st_d.frac_acc = fsum[15:0];
      end
    end

    // Final serial mux; code 3 gives no clock at all
    case (st_q.sfin_eff)
      aocs_pkg::FIN_INT: fin = div_tick[2];
      aocs_pkg::FIN_HALF: fin = st_q.half_tick;
      aocs_pkg::FIN_FRAC: fin = st_q.frac_tick;
      default: fin = 1'b0;
    endcase

    // Registered outputs: a pulse is either passed whole or not at all
    st_d.wifi_out = (st_q.wifi_eff ? div_tick[0] : crystal_clock)
                    && !st_q.r_ga[aocs_pkg::GA_WIFI_OUT];
    st_d.dsi_out = (st_q.dsi_eff ? div_tick[1] : crystal_clock)
                   && !st_q.r_gb[aocs_pkg::GB_DSI];
    st_d.usb_out = (st_q.usb_eff ? div_tick[1] : crystal_clock)
                   && !st_q.r_gb[aocs_pkg::GB_USB];
    st_d.ser_out = fin && !st_q.r_gb[aocs_pkg::GB_SER];
    st_d.d32k_out = crystal_clock && !st_q.r_ga[aocs_pkg::GA_DIV32K];
    st_d.oscd_out = crystal_clock && !st_q.r_ga[aocs_pkg::GA_OSCDIV];
    st_d.mon_out = monitor_src_clock && !st_q.r_gb[aocs_pkg::GB_MON];
    st_d.bus_out = {aocs_pkg::BUS_N{bus_src_clock}}
                   & ~st_q.r_ga[aocs_pkg::BUS_N-1:0];
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= MAIN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Ready held low while a write is parked, which stalls the master
  assign s_axi_awready = !st_q.aw_have && !st_q.bvalid;
  assign s_axi_wready = !st_q.w_have && !st_q.bvalid;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign wifi_clock_out = st_q.wifi_out;
  assign dsi_phy_ref_clock = st_q.dsi_out;
  assign usb_phy_ref_clock = st_q.usb_out;
  assign serial0_clock = st_q.ser_out;
  assign div32k_src_clock = st_q.d32k_out;
  assign oscdiv_src_clock = st_q.oscd_out;
  assign monitor_clock = st_q.mon_out;
  assign bus_clock = st_q.bus_out;

  // Limit of the half-step divider as the assertion sees it
  logic [6:0] lim_chk;
  assign lim_chk = {1'b0, st_q.r_sout[aocs_pkg::HDIV_LSB +: aocs_pkg::SDIV_W], 1'b0}
                   + aocs_pkg::HALF_OFS;

  // ----------------------------------------------------------------
  // Assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_mask_keeps_bits: assert property (
    (wr_now && st_q.awaddr == aocs_pkg::OFF_GATE_A && st_q.wdata[31:16] == 16'h0000)
    |=> $stable(st_q.r_ga))
    else $error("unmasked bits changed");
  a_wifi_from_pll: assert property (
    (st_q.wifi_eff && div_tick[0] && !st_q.r_ga[aocs_pkg::GA_WIFI_OUT]) |=> wifi_clock_out)
    else $error("wireless clock missed a PLL pulse");
  a_dsi_from_xtal: assert property (
    (!st_q.dsi_eff && crystal_clock && !st_q.r_gb[aocs_pkg::GB_DSI]) |=> dsi_phy_ref_clock)
    else $error("display reference missed a crystal pulse");
  a_usb_from_ref: assert property (
    (st_q.usb_eff && div_tick[1] && !st_q.r_gb[aocs_pkg::GB_USB]) |=> usb_phy_ref_clock)
    else $error("USB reference missed a divided pulse");
  a_serial_half: assert property (
    (st_q.sfin_eff == aocs_pkg::FIN_HALF && st_q.half_tick && !st_q.r_gb[aocs_pkg::GB_SER])
    |=> serial0_clock)
    else $error("serial clock missed a half-step pulse");
  a_half_wrap: assert property (
    (div_tick[2] && !st_q.r_gb[aocs_pkg::GB_HALF] &&
     st_q.half_acc + aocs_pkg::HALF_STEP >= lim_chk) |=> st_q.half_tick)
    else $error("half-step divider missed its pulse");
  a_frac_wrap: assert property (
    (div_tick[2] && !st_q.r_gb[aocs_pkg::GB_FRAC] && st_q.r_frac[15:0] != 16'h0000 &&
     st_q.frac_acc + 17'(st_q.r_frac[31:16]) >= 17'(st_q.r_frac[15:0])) |=> st_q.frac_tick)
    else $error("fractional divider missed its pulse");
  a_wifi_gated: assert property (
    st_q.r_ga[aocs_pkg::GA_WIFI_OUT] |=> !wifi_clock_out)
    else $error("wireless clock ran while gated");
  a_div32k_gated: assert property (
    st_q.r_ga[aocs_pkg::GA_DIV32K] |=> !div32k_src_clock)
    else $error("32k divider source ran while gated");
  a_bus_gated: assert property (
    ##1 !(|(bus_clock & $past(st_q.r_ga[aocs_pkg::BUS_N-1:0]))))
    else $error("bus clock ran while gated");
  a_usb_gated: assert property (
    st_q.r_gb[aocs_pkg::GB_USB] |=> !usb_phy_ref_clock)
    else $error("USB reference ran while gated");
  a_serial_gated: assert property (
    st_q.r_gb[aocs_pkg::GB_SER] |=> !serial0_clock)
    else $error("serial clock ran while gated");
  a_select_handover: assert property (
    $changed(st_q.wifi_eff) |-> (!$past(crystal_clock) && !$past(div_tick[0])))
    else $error("wireless select moved during a pulse");

  c_wifi_pll: cover property (st_q.wifi_eff && wifi_clock_out);
  c_serial_half: cover property (st_q.sfin_eff == aocs_pkg::FIN_HALF && serial0_clock);
  c_serial_frac: cover property (st_q.sfin_eff == aocs_pkg::FIN_FRAC && serial0_clock);
  c_masked_write: cover property (wr_now && st_q.wdata[31:16] != 16'hffff);

endmodule : aocs_top
`default_nettype wire

// *** aocs_pkg.sv ***
// Package: register map, field layout and reset values of the always-on clock slice
// Function
// - Upper-half mask bits enable lower-half bit writes
// - Wireless output: crystal or divided general PLL
// - Display PHY reference: crystal or divided 24M
// - USB PHY reference: crystal or divided 24M
// - Serial final mux: integer, half-step, fractional
// - Half-step rate is 2f over 2n+3
// - Fraction: high half numerator, low half denominator
// - Gate A bits 15,14 stop wireless clocks
// - Gate A bits 13,12 stop divider sources
// - Gate A bits 8..0 stop bus clocks
// - Gate B bits 10..8 stop PHY references
// - Gate B bits 4..0 stop monitor, serial branches
package aocs_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFF_WIFI_SEL = 16'hc048;
  localparam logic [15:0] OFF_SER_SRC = 16'hc04c;
  localparam logic [15:0] OFF_SER_OUT = 16'hc050;
  localparam logic [15:0] OFF_SER_FRAC = 16'hc054;
  localparam logic [15:0] OFF_GATE_A = 16'hc080;
  localparam logic [15:0] OFF_GATE_B = 16'hc084;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Writable bits of the masked registers and reset values of all registers
  // ----------------------------------------------------------------
  localparam logic [15:0] WIFI_SEL_RW = 16'hbfff;
  localparam logic [15:0] SER_SRC_RW = 16'hc01f;
  localparam logic [15:0] SER_OUT_RW = 16'hc01f;
  localparam logic [15:0] GATE_A_RW = 16'hf1ff;
  localparam logic [15:0] GATE_B_RW = 16'h071f;
  localparam logic [15:0] WIFI_SEL_RST = 16'h3131;
  localparam logic [15:0] SER_SRC_RST = 16'h000b;
  localparam logic [15:0] SER_OUT_RST = 16'h000b;
  localparam logic [31:0] SER_FRAC_RST = 32'h0001_0014;
  localparam logic [15:0] GATE_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DIV_W = 6;
  localparam int SEL_W = 2;
  localparam int WIFI_SEL_BIT = 15;
  localparam int WDIV_LSB = 8;
  localparam int DSI_SEL_BIT = 7;
  localparam int USB_SEL_BIT = 6;
  localparam int R24_LSB = 0;
  localparam int SPLL_LSB = 14;
  localparam int SDIV_LSB = 0;
  localparam int SDIV_W = 5;
  localparam int SFIN_LSB = 14;
  localparam int HDIV_LSB = 0;
  localparam int FRAC_W = 16;
  localparam int NUM_LSB = 16;
  localparam int DEN_LSB = 0;
  localparam int GA_WIFI_OUT = 15;
  localparam int GA_WIFI_PLL = 14;
  localparam int GA_DIV32K = 13;
  localparam int GA_OSCDIV = 12;
  localparam int BUS_N = 9;
  localparam int GB_DSI = 10;
  localparam int GB_USB = 9;
  localparam int GB_R24PLL = 8;
  localparam int GB_MON = 4;
  localparam int GB_SER = 3;
  localparam int GB_FRAC = 2;
  localparam int GB_HALF = 1;
  localparam int GB_SPLL = 0;

  // ----------------------------------------------------------------
  // Select codes and half-step constants
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_GPLL = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_USB480 = 2'h2;
  localparam logic [1:0] SRC_NPLL = 2'h3;
  localparam logic [1:0] FIN_INT = 2'h0;
  localparam logic [1:0] FIN_HALF = 2'h1;
  localparam logic [1:0] FIN_FRAC = 2'h2;
  localparam logic [6:0] HALF_STEP = 7'h02;
  localparam logic [6:0] HALF_OFS = 7'h03;

endpackage : aocs_pkg

// *** aocs_div_if.sv ***
// Interface: pulse-stream integer divider connection
`timescale 1ns/1ps
`default_nettype none
interface aocs_div_if;
  logic tick_in;
  logic run;
  logic [aocs_pkg::DIV_W-1:0] divisor;
  logic tick_out;
  modport div (input tick_in, input run, input divisor, output tick_out);
  modport user (output tick_in, output run, output divisor, input tick_out);
endinterface : aocs_div_if
`default_nettype wire

// *** aocs_int_div.sv ***
// Module: integer divider on a pulse stream, one output pulse per divisor+1 inputs
`timescale 1ns/1ps
`default_nettype none
module aocs_int_div (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  aocs_div_if.div dv // Source pulses in, divided pulses out
);

  typedef struct packed {
    logic [aocs_pkg::DIV_W-1:0] cnt;
    logic tick;
  } aocs_div_st_t;

  localparam aocs_div_st_t DIV_RST = '{cnt: 6'h00, tick: 1'b0};

  aocs_div_st_t st_q;
  aocs_div_st_t st_d;

  // Count only while the source gate is open; a closed gate freezes the phase
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (dv.tick_in && dv.run) begin
      if (st_q.cnt >= dv.divisor) begin
        st_d.cnt = 6'h00;
        st_d.tick = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 6'h01;
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= DIV_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign dv.tick_out = st_q.tick; // Whole pulse from a flop

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_div_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (dv.tick_in && dv.run && st_q.cnt >= dv.divisor) |=> dv.tick_out)
    else $error("divider missed its wrap pulse");
  a_div_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !dv.run |=> !dv.tick_out)
    else $error("divider pulsed with its source gated");

endmodule : aocs_int_div
`default_nettype wire

// *** aocs_tb_top.sv ***
// Testbench: register and clock-path checks of the always-on clock slice
`timescale 1ns/1ps
`default_nettype none
module aocs_tb_top;
  // ----------------------------------------------------------------
  // Stimulus, bus tasks and checks
  // ----------------------------------------------------------------
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [15:0] awaddr = 16'h0;
  logic [15:0] araddr = 16'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, wifi, dsi, usb;
  logic ser, d32k, oscd, mon;
  logic [1:0] bresp;
  logic [1:0] wresp = 2'h0;
  logic crystal = 1'h0;
  logic gpll = 1'h0;
  logic mon_src = 1'h0;
  logic bus_src = 1'h0;
  logic [8:0] bus_clock;
  int fail_count = 0;
  int cmp_count = 0;
  int i;
  // Every readable register in map order, with its reset image
  logic [15:0] addr_tab [6] = '{16'hc048, 16'hc04c, 16'hc050, 16'hc054, 16'hc080, 16'hc084};
  logic [31:0] rst_tab [6] = '{32'h3131, 32'h000b, 32'h000b, 32'h0001_0014, 32'h0, 32'h0};

  always #50 aclk = ~aclk;

  // Idle sources tied low; all byte lanes strobed
  aocs_top u_aocs_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .crystal_clock(crystal), .gpll_clock(gpll), .usbphy480_clock(1'h0), .npll_clock(1'h0),
    .monitor_src_clock(mon_src), .bus_src_clock(bus_src), .wifi_clock_out(wifi),
    .dsi_phy_ref_clock(dsi), .usb_phy_ref_clock(usb), .serial0_clock(ser),
    .div32k_src_clock(d32k), .oscdiv_src_clock(oscd), .monitor_clock(mon),
    .bus_clock(bus_clock));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  // Ready is sampled mid-cycle: it is stable up to the next rising edge
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic ra, rw, rb;
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      if (!awvalid && !wvalid && !bready) break;
      ra = awready;
      rw = wready;
      rb = bvalid;
      if (rb) wresp = bresp;
      @(posedge aclk);
      if (ra) awvalid <= 1'h0;
      if (rw) wvalid <= 1'h0;
      if (rb) bready <= 1'h0;
    end
    if (n == 40) begin
      fail_count++;
      end_of_test();
    end
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ra, rb;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      if (!arvalid && !rready) break;
      ra = arready;
      rb = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ra) arvalid <= 1'h0;
      if (rb) rready <= 1'h0;
    end
    if (n == 40) begin
      fail_count++;
      end_of_test();
    end
    chk(d, exp);
    chk({30'h0, r}, {30'h0, er});
  endtask : rdc

  // One source pulse; gated outputs answer in the following cycle
  task automatic pulse(input logic [5:0] exp_ref, input logic [8:0] exp_bus);
    @(posedge aclk);
    crystal <= 1'h1;
    bus_src <= 1'h1;
    mon_src <= 1'h1;
    @(posedge aclk);
    crystal <= 1'h0;
    bus_src <= 1'h0;
    mon_src <= 1'h0;
    #1;
    chk({26'h0, wifi, dsi, usb, d32k, oscd, mon}, {26'h0, exp_ref});
    chk({23'h0, bus_clock}, {23'h0, exp_bus});
  endtask : pulse

  // PLL pulse on n cycles; outputs counted until the divider pipe has drained
  task automatic spin(input int n, input logic [31:0] exp_ser, input logic [31:0] exp_wifi);
    logic [31:0] cs, cw;
    int k;
    cs = 32'h0;
    cw = 32'h0;
    @(posedge aclk);
    gpll <= 1'h1;
    for (k = 0; k < n + 4; k++) begin
      @(posedge aclk);
      if (k == n - 1) gpll <= 1'h0;
      #1;
      cs = cs + ser;
      cw = cw + wifi;
    end
    chk(cs, exp_ser);
    chk(cw, exp_wifi);
  endtask : spin

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    for (i = 0; i < 6; i++) rdc(addr_tab[i], rst_tab[i], 2'h0);
    rdc(16'hc060, 32'h0, 2'h2);
    $display("test reset values done");
    wr(16'hc060, 32'hffff_ffff);
    chk({30'h0, wresp}, 32'h2);
    wr(16'hc048, 32'h0000_0000);
    chk({30'h0, wresp}, 32'h0);
    rdc(16'hc048, 32'h3131, 2'h0);
    wr(16'hc080, 32'ha001_ffff);
    rdc(16'hc080, 32'ha001, 2'h0);
    pulse(6'h1b, 9'h1fe);
    wr(16'hc080, 32'hffff_0000);
    pulse(6'h3f, 9'h1ff);
    wr(16'hc084, 32'h0610_0610);
    pulse(6'h26, 9'h1ff);
    $display("test gates and selects done");
    wr(16'hc054, 32'h0001_0000);
    wr(16'hc04c, 32'h001f_0000);
    wr(16'hc050, 32'hc01f_4000);
    spin(6, 4, 0);
    wr(16'hc054, 32'h0001_0003);
    wr(16'hc050, 32'hc000_8000);
    spin(6, 2, 0);
    wr(16'hc050, 32'hc000_0000);
    wr(16'hc048, 32'hbf00_8000);
    spin(6, 6, 6);
    $display("test serial and wireless paths done");
    wr(16'hc054, 32'h1234_5678);
    rdc(16'hc054, 32'h1234_5678, 2'h0);
    $display("test fraction register done");
    end_of_test();
  end
endmodule : aocs_tb_top
`default_nettype wire
